/* hdl/pwtf_pkg.sv */
package pwtf_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
    localparam int OC_PERIOD_S   = 4;
    localparam int OC_PERIOD_MS  = OC_PERIOD_S * 1000;
    localparam int OC_ON_MS_I    = 125;
    localparam int TEMP_PERIOD_MS = 100;
    localparam int FILTER_MS     = 500;
    localparam logic [6:0] OC_ON_MS   = 7'(OC_ON_MS_I);
    localparam logic [3:0] POWERUP_MS = 4'h2;
    localparam logic [3:0] PULL_MS    = 4'h1;
    localparam logic [3:0] BIAS_MS    = 4'h1;
    localparam int NUM_CELLS_DEF = 10;
    localparam int CELL_IDX_W    = 4;

    typedef enum logic [3:0] {
        MODE_SHUTDOWN = 4'h1,
        MODE_POWERUP  = 4'h2,
        MODE_ACTIVE   = 4'h4,
        MODE_LOWPOWER = 4'h8
    } pwtf_mode_e;

    typedef enum logic [2:0] {
        TCHK_IDLE = 3'h1,
        TCHK_PULL = 3'h2,
        TCHK_BIAS = 3'h4
    } pwtf_tchk_e;

    typedef struct packed {
        pwtf_mode_e            mode;
        logic                  ret_wake;
        logic                  chrg_wake;
        logic                  short_lock;
        logic                  chrg_q;
        logic [3:0]            pu_cnt;
        pwtf_tchk_e            tchk;
        logic [3:0]            tchk_cnt;
        logic                  ext_pu;
        logic                  ovt;
        logic                  opn;
        logic                  oc_on;
        logic [CELL_IDX_W-1:0] oc_idx;
        logic [6:0]            oc_cnt;
        logic                  reg_en;
        logic                  fet_on;
        logic                  bias;
        logic                  pulldn;
    } pwtf_state_s;
endpackage : pwtf_pkg

/* hdl/pwtf_tick.sv */
// Divider: one-cycle pulse every LIMIT enables, held at zero by clr
module pwtf_tick
    import pwtf_pkg::*;
#(
    parameter int LIMIT = 4
)(
    input  wire logic clk_in,   // System clock
    input  wire logic nrst_in,  // Async reset, active low
    input  wire logic clr_in,   // Synchronous clear
    input  wire logic en_in,    // Count enable
    output logic      tick_out  // Pulse on last count
);
    localparam int W = $clog2(LIMIT + 1);
    localparam logic [W-1:0] LAST = W'(LIMIT - 1);

    typedef struct packed {
        logic [W-1:0] cnt;
    } pwtf_tick_s;

    pwtf_tick_s st_r;
    pwtf_tick_s st_nxt;

    // Pulse is combinational so the consumer sees it in the counting cycle
    assign tick_out = en_in && !clr_in && (st_r.cnt == LAST);

    // Next count
    always_comb
    begin
        st_nxt = st_r;
        if (clr_in)
            st_nxt.cnt = '0;
        else if (en_in)
            st_nxt.cnt = (st_r.cnt == LAST) ? '0 : W'(st_r.cnt + 1'b1);
    end

    // State register
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
endmodule : pwtf_tick

/* hdl/pwtf_ctrl.sv */
// Wake, shutdown, thermistor fault and open-cell sequencing
module pwtf_ctrl
    import pwtf_pkg::*;
#(
    parameter int MS_CYC    = MS_CYCLES,    // Clock cycles per millisecond
    parameter int NUM_CELLS = NUM_CELLS_DEF // Cells in the stack
)(
    input  wire logic                 CLK_IN,               // 100 MHz clock
    input  wire logic                 NRST_IN,              // Async reset, active low
    input  wire logic                 CHARGER_SENSE_IN,     // Comparator: above 0.5 V
    input  wire logic                 CHARGER_RETURN_IN,    // Comparator: below ground - 2 V
    input  wire logic                 THERM_SHORT_IN,       // Sense below short threshold
    input  wire logic                 THERM_OPEN_IN,        // Sense above open threshold
    input  wire logic                 THERM_HOT_IN,         // Sense below hot threshold
    input  wire logic                 THERM_EXT_PU_IN,      // Sense above ext pullup level
    input  wire logic                 FAULT_IN,             // Other protection fault present
    input  wire logic                 CFG_FAULT_SHDN_IN,    // 1: fault after charger wake shuts down
    input  wire logic                 FET_REQ_IN,           // Protection logic wants FETs on
    output logic                      REGULATOR_EN_OUT,     // Internal regulator enable
    output logic                      DISCHARGE_FET_DRIVE_OUT, // Discharge FET on
    output logic                      CHARGE_FET_DRIVE_OUT, // Charge FET on
    output logic                      THERMISTOR_BIAS_OUT,  // Thermistor bias drive
    output logic                      THERM_PULLDOWN_OUT,   // Weak pulldown on sense
    output logic [NUM_CELLS-1:0]      OPEN_CELL_LOAD_OUT,   // Test load per cell
    output logic                      OVERTEMP_OUT,         // Overtemperature fault
    output logic                      OPEN_THERM_OUT,       // Open or cold thermistor
    output logic                      SHORT_LOCK_OUT,       // Shut down by shorted thermistor
    output logic [3:0]                MODE_OUT              // One-hot operating mode
);
    localparam logic [CELL_IDX_W-1:0] LAST_CELL = CELL_IDX_W'(NUM_CELLS - 1);

    pwtf_state_s st_r;
    pwtf_state_s st_nxt;
    logic        ms_tick;
    logic        oc_tick;
    logic        temp_tick;
    logic        chrg_rise;
    logic        not_active;

    assign not_active = (st_r.mode != MODE_ACTIVE);
    // Wake needs a fresh appearance, so a charger left in place cannot loop a fault wake
    assign chrg_rise = CHARGER_SENSE_IN && !st_r.chrg_q;

    // Millisecond time base; stopped in shutdown with the rest of the logic
    pwtf_tick #(.LIMIT(MS_CYC)) u_ms (
        .clk_in   (CLK_IN),
        .nrst_in  (NRST_IN),
        .clr_in   (st_r.mode == MODE_SHUTDOWN),
        .en_in    (1'b1),
        .tick_out (ms_tick)
    );

    // Open-cell check period
    pwtf_tick #(.LIMIT(OC_PERIOD_MS)) u_oc (
        .clk_in   (CLK_IN),
        .nrst_in  (NRST_IN),
        .clr_in   (not_active),
        .en_in    (ms_tick),
        .tick_out (oc_tick)
    );

    // Thermistor check period
    pwtf_tick #(.LIMIT(TEMP_PERIOD_MS)) u_temp (
        .clk_in   (CLK_IN),
        .nrst_in  (NRST_IN),
        .clr_in   (not_active),
        .en_in    (ms_tick),
        .tick_out (temp_tick)
    );

    // Next state and registered outputs
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.chrg_q = CHARGER_SENSE_IN;
        case (st_r.mode)
            MODE_SHUTDOWN:
            begin
                if (chrg_rise)
                begin
                    st_nxt.mode       = MODE_POWERUP;
                    st_nxt.chrg_wake  = 1'b1;
                    st_nxt.ret_wake   = 1'b0;
                    st_nxt.short_lock = 1'b0;
                    st_nxt.pu_cnt     = '0;
                end
                else if (CHARGER_RETURN_IN && !st_r.short_lock)
                begin
                    st_nxt.mode     = MODE_POWERUP;
                    st_nxt.ret_wake  = 1'b1;
                    st_nxt.chrg_wake = 1'b0;
                    st_nxt.pu_cnt   = '0;
                end
            end
            MODE_POWERUP:
            begin
                if (ms_tick)
                begin
                    st_nxt.pu_cnt = 4'(st_r.pu_cnt + 1'b1);
                    if (st_r.pu_cnt == POWERUP_MS - 4'h1)
                    begin
                        st_nxt.chrg_wake = 1'b0;
                        st_nxt.mode      = MODE_ACTIVE;
                        if (st_r.chrg_wake && FAULT_IN)
                            st_nxt.mode = CFG_FAULT_SHDN_IN ? MODE_SHUTDOWN : MODE_LOWPOWER;
                    end
                end
            end
            MODE_ACTIVE:
            begin
                // Thermistor check: pulldown phase, then bias phase, then evaluate
                case (st_r.tchk)
                    TCHK_IDLE:
                    begin
                        if (temp_tick)
                        begin
                            st_nxt.tchk     = TCHK_PULL;
                            st_nxt.tchk_cnt = '0;
                        end
                    end
                    TCHK_PULL:
                    begin
                        if (ms_tick)
                        begin
                            st_nxt.tchk_cnt = 4'(st_r.tchk_cnt + 1'b1);
                            if (st_r.tchk_cnt == PULL_MS - 4'h1)
                            begin
                                st_nxt.ext_pu   = THERM_EXT_PU_IN;
                                st_nxt.tchk     = TCHK_BIAS;
                                st_nxt.tchk_cnt = '0;
                            end
                        end
                    end
                    TCHK_BIAS:
                    begin
                        if (ms_tick)
                        begin
                            st_nxt.tchk_cnt = 4'(st_r.tchk_cnt + 1'b1);
                            if (st_r.tchk_cnt == BIAS_MS - 4'h1)
                            begin
                                st_nxt.tchk = TCHK_IDLE;
                                // A clean check clears open within one period, below filter
                                st_nxt.opn  = 1'b0;
                                st_nxt.ovt  = 1'b0;
                                if (THERM_SHORT_IN)
                                begin
                                    st_nxt.mode       = MODE_SHUTDOWN;
                                    st_nxt.short_lock = 1'b1;
                                end
                                else if (THERM_OPEN_IN)
                                    st_nxt.opn = 1'b1;
                                else if (THERM_HOT_IN)
                                    st_nxt.ovt = 1'b1;
                            end
                        end
                    end
                    default:
                        st_nxt.tchk = TCHK_IDLE;
                endcase
                // Open-cell load walks the cells one at a time
                if (oc_tick)
                begin
                    st_nxt.oc_on  = 1'b1;
                    st_nxt.oc_cnt = '0;
                end
                else if (st_r.oc_on && ms_tick)
                begin
                    st_nxt.oc_cnt = 7'(st_r.oc_cnt + 1'b1);
                    if (st_r.oc_cnt == OC_ON_MS - 7'h01)
                    begin
                        st_nxt.oc_on  = 1'b0;
                        st_nxt.oc_idx = (st_r.oc_idx == LAST_CELL) ? '0 :
                                        CELL_IDX_W'(st_r.oc_idx + 1'b1);
                    end
                end
            end
            MODE_LOWPOWER:
            begin
                if (!FAULT_IN)
                    st_nxt.mode = MODE_ACTIVE;
            end
            default:
                st_nxt.mode = MODE_SHUTDOWN;
        endcase
        // A return-pin wake lasts only while the pin is held, unless a charger latches it
        if (st_r.ret_wake && st_r.mode != MODE_SHUTDOWN)
        begin
            if (CHARGER_SENSE_IN)
                st_nxt.ret_wake = 1'b0;
            else if (!CHARGER_RETURN_IN)
            begin
                st_nxt.mode     = MODE_SHUTDOWN;
                st_nxt.ret_wake = 1'b0;
            end
        end
        // Checks stop outside active mode; overtemp and open faults are forgotten in shutdown, the short lock is kept
        if (st_nxt.mode != MODE_ACTIVE)
        begin
            st_nxt.tchk  = TCHK_IDLE;
            st_nxt.oc_on = 1'b0;
        end
        if (st_nxt.mode == MODE_SHUTDOWN)
        begin
            st_nxt.ovt      = 1'b0;
            st_nxt.opn      = 1'b0;
            st_nxt.chrg_wake = 1'b0;
        end
        st_nxt.reg_en = (st_nxt.mode != MODE_SHUTDOWN);
        st_nxt.fet_on = (st_nxt.mode == MODE_ACTIVE) && !st_nxt.ovt && !st_nxt.opn &&
                        FET_REQ_IN;
        st_nxt.pulldn = (st_nxt.tchk != TCHK_IDLE);
        st_nxt.bias   = (st_nxt.tchk == TCHK_BIAS) && !st_nxt.ext_pu;
    end

    // State register
    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            st_r      <= '0;
            st_r.mode <= MODE_SHUTDOWN;
            st_r.tchk <= TCHK_IDLE;
        end
        else
            st_r <= st_nxt;
    end

    // Output mapping
    assign REGULATOR_EN_OUT        = st_r.reg_en;
    assign DISCHARGE_FET_DRIVE_OUT = st_r.fet_on;
    assign CHARGE_FET_DRIVE_OUT    = st_r.fet_on;
    assign THERMISTOR_BIAS_OUT     = st_r.bias;
    assign THERM_PULLDOWN_OUT      = st_r.pulldn;
    assign OVERTEMP_OUT            = st_r.ovt;
    assign OPEN_THERM_OUT          = st_r.opn;
    assign SHORT_LOCK_OUT          = st_r.short_lock;
    assign MODE_OUT                = st_r.mode;

    // Only the indexed cell gets the load
    always_comb
    begin
        OPEN_CELL_LOAD_OUT = '0;
        for (int i = 0; i < NUM_CELLS; i++)
            OPEN_CELL_LOAD_OUT[i] = st_r.oc_on && (st_r.oc_idx == CELL_IDX_W'(i));
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);

    property p_one_load;
        $onehot0(OPEN_CELL_LOAD_OUT) && (st_r.oc_cnt < OC_ON_MS || !st_r.oc_on);
    endproperty
    a_one_load: assert property (p_one_load) else $error("open-cell load bad");

    property p_shdn_off;
        (st_r.mode == MODE_SHUTDOWN) |-> !REGULATOR_EN_OUT && !THERM_PULLDOWN_OUT;
    endproperty
    a_shdn_off: assert property (p_shdn_off) else $error("logic on in shutdown");

    property p_fet_off;
        (!REGULATOR_EN_OUT || st_r.mode == MODE_POWERUP) |->
            !DISCHARGE_FET_DRIVE_OUT && !CHARGE_FET_DRIVE_OUT;
    endproperty
    a_fet_off: assert property (p_fet_off) else $error("FET on without regulator");

    property p_chg_wake;
        (st_r.mode == MODE_SHUTDOWN) && chrg_rise |=>
            (st_r.mode == MODE_POWERUP) ##1 REGULATOR_EN_OUT;
    endproperty
    a_chg_wake: assert property (p_chg_wake) else $error("no charger wake");

    property p_ret_wake;
        (st_r.mode == MODE_SHUTDOWN) && CHARGER_RETURN_IN && !st_r.short_lock && !chrg_rise
            |=> st_r.ret_wake && (st_r.mode == MODE_POWERUP);
    endproperty
    a_ret_wake: assert property (p_ret_wake) else $error("no return-pin wake");

    property p_ret_drop;
        st_r.ret_wake && (st_r.mode != MODE_SHUTDOWN) && !CHARGER_SENSE_IN &&
            !CHARGER_RETURN_IN |=> (st_r.mode == MODE_SHUTDOWN) ##1 !REGULATOR_EN_OUT;
    endproperty
    a_ret_drop: assert property (p_ret_drop) else $error("return wake latched");

    property p_bias;
        THERMISTOR_BIAS_OUT |-> (st_r.tchk == TCHK_BIAS) && !st_r.ext_pu && THERM_PULLDOWN_OUT;
    endproperty
    a_bias: assert property (p_bias) else $error("bias outside reading");

    property p_hot_fet;
        OVERTEMP_OUT || OPEN_THERM_OUT |-> !DISCHARGE_FET_DRIVE_OUT && REGULATOR_EN_OUT;
    endproperty
    a_hot_fet: assert property (p_hot_fet) else $error("FET on with thermal fault");

    property p_short;
        (st_r.tchk == TCHK_BIAS) && ms_tick && (st_r.tchk_cnt == BIAS_MS - 4'h1) &&
            THERM_SHORT_IN && !st_nxt.ret_wake |=> SHORT_LOCK_OUT && (st_r.mode == MODE_SHUTDOWN);
    endproperty
    a_short: assert property (p_short) else $error("short not shut down");

    property p_lock;
        SHORT_LOCK_OUT && (st_r.mode == MODE_SHUTDOWN) && !chrg_rise |=>
            (st_r.mode == MODE_SHUTDOWN);
    endproperty
    a_lock: assert property (p_lock) else $error("woke without charger");

    property p_order;
        OVERTEMP_OUT |-> !OPEN_THERM_OUT;
    endproperty
    a_order: assert property (p_order) else $error("two thermal faults");

    c_active: cover property ((st_r.mode == MODE_POWERUP) ##1 (st_r.mode == MODE_ACTIVE));
    c_bias: cover property ($rose(THERMISTOR_BIAS_OUT));
    c_ovt: cover property ($rose(OVERTEMP_OUT));
    c_load: cover property ($rose(st_r.oc_on));
endmodule : pwtf_ctrl

/* test/pwtf_partner.sv */
// Charger and pack thermistor as the block sees them through its comparators
module pwtf_partner
    import pwtf_pkg::*;
(
    input  wire logic       clk_in,     // System clock
    input  wire logic       chrg_on_in, // Charger plugged in and powered
    input  wire logic       ret_on_in,  // Charger return pulled below ground - 2 V
    input  wire logic [1:0] therm_in,   // 0 normal, 1 hot, 2 open, 3 shorted
    input  wire logic       ext_in,     // Charger biases the thermistor itself
    input  wire logic       bias_in,    // Bias drive from the block
    input  wire logic       pull_in,    // Weak pulldown from the block
    output logic            sense_out,  // Charger-sense comparator
    output logic            ret_out,    // Charger-return comparator
    output logic            short_out,  // Sense below short threshold
    output logic            open_out,   // Sense above open threshold
    output logic            hot_out,    // Sense below hot threshold
    output logic            ext_pu_out  // Sense above external pullup level
);
    logic idle_r = 1'b0;

    // Undriven sense line wanders, so a reading outside a check is never trustworthy
    always @(posedge clk_in)
        idle_r <= ~idle_r;

    assign sense_out = chrg_on_in;
    assign ret_out   = ret_on_in;

    // Sense level: thermistor divider when biased, ground under the pulldown alone
    always_comb
    begin
        if (ext_in || bias_in)
        begin
            short_out = (therm_in == 2'h3);
            hot_out   = (therm_in == 2'h1) || (therm_in == 2'h3);
            open_out  = (therm_in == 2'h2);
        end
        else if (pull_in)
        begin
            short_out = 1'b1;
            hot_out   = 1'b1;
            open_out  = 1'b0;
        end
        else
        begin
            short_out = idle_r;
            hot_out   = idle_r;
            open_out  = ~idle_r;
        end
        // A shorted thermistor pulls even an external bias to ground
        ext_pu_out = ext_in ? (therm_in != 2'h3) : (pull_in ? 1'b0 : idle_r);
    end
endmodule : pwtf_partner

/* test/pwtf_ctrl_bench.sv */
// Self-checking bench for the wake, shutdown and thermistor controller
module pwtf_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MSC    = 5;      // Shortened millisecond keeps the 4 s cell period short
    localparam int WD_CYC = 60000;  // Whole run needs about 42000 cycles
    logic clk = 1'b0, nrst = 1'b0, chrg_on = 1'b0, ret_on = 1'b0, ext = 1'b0;
    logic fault = 1'b0, cfg = 1'b0, fet_req = 1'b1;
    logic [1:0] therm = 2'h0;
    logic sense, ret, th_short, th_open, th_hot, th_ext, reg_en, disch_drv, charge_drv;
    logic bias, pull;
    logic ovt, opn, lock;
    logic [3:0] load, mode;
    int num_errors = 0;
    int n_checks = 0;

    always #5 clk = ~clk;

    pwtf_ctrl #(.MS_CYC(MSC), .NUM_CELLS(4)) dut_u (
        .CLK_IN(clk), .NRST_IN(nrst), .CHARGER_SENSE_IN(sense), .CHARGER_RETURN_IN(ret),
        .THERM_SHORT_IN(th_short), .THERM_OPEN_IN(th_open), .THERM_HOT_IN(th_hot),
        .THERM_EXT_PU_IN(th_ext), .FAULT_IN(fault), .CFG_FAULT_SHDN_IN(cfg),
        .FET_REQ_IN(fet_req), .REGULATOR_EN_OUT(reg_en), .DISCHARGE_FET_DRIVE_OUT(disch_drv),
        .CHARGE_FET_DRIVE_OUT(charge_drv), .THERMISTOR_BIAS_OUT(bias),
        .THERM_PULLDOWN_OUT(pull),
        .OPEN_CELL_LOAD_OUT(load), .OVERTEMP_OUT(ovt), .OPEN_THERM_OUT(opn),
        .SHORT_LOCK_OUT(lock), .MODE_OUT(mode));

    pwtf_partner far_u (
        .clk_in(clk), .chrg_on_in(chrg_on), .ret_on_in(ret_on), .therm_in(therm),
        .ext_in(ext), .bias_in(bias), .pull_in(pull), .sense_out(sense), .ret_out(ret),
        .short_out(th_short), .open_out(th_open), .hot_out(th_hot), .ext_pu_out(th_ext));

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report

    // Inputs move just after the edge so the block never sees them change at sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wait_mode(input logic [3:0] m, input int lim);
        int i;
        for (i = 0; i < lim && mode !== m; i++)
            step(1);
        chk("mode", mode, m);
    endtask : wait_mode

    // Runs through one whole thermistor check, noting whether own bias was driven
    task automatic wait_check(output logic saw);
        int i;
        saw = 1'b0;
        for (i = 0; i < 20 && pull === 1'b1; i++)
            step(1);
        for (i = 0; i < 600 && pull !== 1'b1; i++)
            step(1);
        chk("pulldown", pull, 1'b1);
        for (i = 0; i < 20 && pull === 1'b1; i++)
        begin
            saw |= bias;
            step(1);
        end
        step(2);
    endtask : wait_check

    task automatic t_wake(input logic f, input logic c, input logic [3:0] endm);
        fault = f;
        cfg = c;
        chrg_on = 1'b0;
        step(2);
        chk("pre_wake", mode, 4'h1);
        chrg_on = 1'b1;
        step(1);
        chk("wake_mode", mode, 4'h2);
        chk("wake_reg", reg_en, 1'b1);
        chk("powerup_fets", {disch_drv, charge_drv}, 2'h0);
        chk("lock_cleared", lock, 1'b0);
        wait_mode(endm, 3 * MSC);
        step(1);
        chk("fets_after", {disch_drv, charge_drv}, {2{endm == 4'h4}});
        $display("test charger wake to mode %0h done", endm);
    endtask : t_wake

    task automatic t_open_cell();
        int i, n;
        logic [3:0] first;
        for (i = 0; i < 20100 && load === 4'h0; i++)
            step(1);
        first = load;
        chk("load_seen", first != 4'h0, 1'b1);
        for (n = 0; n < 700 && load === first; n++)
            step(1);
        chk("load_on_cycles", n, 125 * MSC);
        for (i = 0; i < 20100 && load === 4'h0; i++)
            step(1);
        chk("load_period", n + i, 4000 * MSC);
        chk("load_next_cell", load, {first[2:0], first[3]});
        $display("test open cell done");
    endtask : t_open_cell

    task automatic t_therm();
        logic saw;
        therm = 2'h1;
        wait_check(saw);
        chk("own_bias", saw, 1'b1);
        chk("overtemp", ovt, 1'b1);
        chk("awake_hot", mode, 4'h4);
        chk("fets_hot", {disch_drv, charge_drv}, 2'h0);
        therm = 2'h2;
        wait_check(saw);
        chk("open_therm", opn, 1'b1);
        chk("awake_open", mode, 4'h4);
        chk("fets_open", {disch_drv, charge_drv}, 2'h0);
        therm = 2'h0;
        ext = 1'b1;
        wait_check(saw);
        chk("ext_bias_off", saw, 1'b0);
        chk("faults_cleared", {opn, ovt}, 2'h0);
        chk("fets_back", {disch_drv, charge_drv}, 2'h3);
        ext = 1'b0;
        $display("test thermistor faults done");
    endtask : t_therm

    task automatic t_short();
        logic saw;
        therm = 2'h3;
        wait_check(saw);
        chk("short_mode", mode, 4'h1);
        chk("short_lock", lock, 1'b1);
        chk("short_reg_off", reg_en, 1'b0);
        therm = 2'h0;
        ret_on = 1'b1;
        step(5);
        chk("ret_refused", mode, 4'h1);
        ret_on = 1'b0;
        $display("test shorted thermistor done");
    endtask : t_short

    task automatic t_return();
        chrg_on = 1'b0;
        fault = 1'b0;
        step(2);
        ret_on = 1'b1;
        step(1);
        chk("ret_wake", mode, 4'h2);
        chk("ret_reg", reg_en, 1'b1);
        step(3);
        chk("ret_hold", mode, 4'h2);
        ret_on = 1'b0;
        step(1);
        chk("ret_release", mode, 4'h1);
        $display("test return wake done");
    endtask : t_return

    // Standing checks, sampled mid-cycle where every output has settled
    always @(negedge clk)
    begin
        if (nrst)
        begin
            chk("one_load", $onehot0(load), 1'b1);
            chk("bias_outside", bias & ~pull, 1'b0);
            chk("fets_reg_off", (disch_drv | charge_drv) & ~reg_en, 1'b0);
            chk("reg_shutdown", reg_en & mode[0], 1'b0);
        end
    end

    initial
    begin
        repeat (3) @(posedge clk);
        #1;
        nrst = 1'b1;
        chk("reset_mode", mode, 4'h1);
        chk("reset_outs", {reg_en, disch_drv, charge_drv, bias, pull, load}, 9'h000);
        $display("test reset done");
        t_wake(1'b0, 1'b0, 4'h4);
        t_open_cell();
        t_therm();
        t_short();
        t_wake(1'b1, 1'b1, 4'h1);
        t_return();
        t_wake(1'b1, 1'b0, 4'h8);
        fault = 1'b0;
        wait_mode(4'h4, 4);
        $display("test low power recovery done");
        final_report();
    end

    // Cuts a hang short
    initial
    begin
        #(WD_CYC * 10);
        num_errors++;
        final_report();
    end
endmodule : pwtf_ctrl_bench
